// file: inc/aidr_consts.svh
// Purpose: Constants of the analog input diagnostic record
// Assumes: 40 MHz system clock
// Notes:   Byte offsets are positions within the record
`ifndef AIDR_CONSTS_SVH
`define AIDR_CONSTS_SVH

// ****************************************************************
// Record byte offsets
// ****************************************************************
`define AIDR_OFF_DIAG_A      5'h00
`define AIDR_OFF_MODINFO     5'h01
`define AIDR_OFF_RSVD_C      5'h02
`define AIDR_OFF_DIAG_D      5'h03
`define AIDR_OFF_CHTYPE      5'h04
`define AIDR_OFF_DIAG_BITS_PER_CHANNEL      5'h05
`define AIDR_OFF_CHANNEL_COUNT       5'h06
`define AIDR_OFF_CHSUM       5'h07
`define AIDR_OFF_CHERR0      5'h08
`define AIDR_OFF_CHERR7      5'h0f
`define AIDR_OFF_RSVD_10     5'h10
`define AIDR_OFF_TS0         5'h11
`define AIDR_OFF_TS3         5'h14

// ****************************************************************
// Field positions and values
// ****************************************************************
`define AIDR_CLASS_ANALOG    4'h5
`define AIDR_MODINFO_CHBIT   4
`define AIDR_DIAGD_COMBIT    4
`define AIDR_DIAGA_CHBIT     3
`define AIDR_CHTYPE_AI       7'h71
`define AIDR_DIAG_BITS_PER_CHANNEL_VAL      8'h08
`define AIDR_CHANNEL_COUNT_VAL       8'h08
`define AIDR_CHANNEL_ERROR_SUMMARY_PARBIT    0
`define AIDR_CHANNEL_ERROR_SUMMARY_UNDBIT    6
`define AIDR_CHANNEL_ERROR_SUMMARY_OVRBIT    7

// ****************************************************************
// Timing
// ****************************************************************
`define AIDR_CLK_HZ          40000000
`define AIDR_TICK_NS         1000
`define AIDR_CLK_NS          25
`define AIDR_TICK_CYCLES     (`AIDR_TICK_NS / `AIDR_CLK_NS)

`endif

// file: inc/aidr_pkg.sv
// Purpose: Types of the analog input diagnostic record
// Assumes: Nothing
// Notes:   Constants live in aidr_consts.svh
`default_nettype none
package aidr_pkg;
    typedef logic [7:0]  aidr_byte_type;
    typedef logic [31:0] aidr_stamp_type;
    typedef logic [4:0]  aidr_addr_type;
endpackage
`default_nettype wire

// file: logic/aidr_ticker.sv
// Purpose: Free-running 32-bit microsecond ticker
// Assumes: Synchronous active-high reset at power-on
// Notes:   Wraps to zero after the all-ones count
`include "aidr_consts.svh"
`default_nettype none
module aidr_ticker
    import aidr_pkg::*;
(
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst,
    // Ticker value
    output var  aidr_pkg::aidr_stamp_type us_count
);
    import aidr_pkg::*;

    localparam logic [5:0] PRE_LAST = 6'(`AIDR_TICK_CYCLES - 1);

    logic [5:0] pre_reg;

    // ************************************************************
    // Prescaler, one enable per microsecond
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst || pre_reg == PRE_LAST) begin
            pre_reg <= 6'h00;
        end else begin
            pre_reg <= pre_reg + 6'h01;
        end
    end

    // Count microseconds, start at zero, roll over
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            us_count <= 32'h0000_0000;
        end else if (pre_reg == PRE_LAST) begin
            us_count <= us_count + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// file: logic/aidr_record.sv
// Purpose: Read-only diagnostic record of an 8-channel analog input
// Assumes: Status inputs synchronous to clk_sys; byte-wide read port
// Notes:   Read data is registered, valid one cycle after rd_en
`include "aidr_consts.svh"
`default_nettype none
module aidr_record
    import aidr_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    // Channel and communication conditions
    input  wire logic [7:0]              ch_param_err,
    input  wire logic [7:0]              ch_underflow,
    input  wire logic [7:0]              ch_overflow,
    input  wire logic                    int_comm_err,
    // Record read port
    input  wire logic                    rd_en,
    input  wire aidr_pkg::aidr_addr_type rd_addr,
    output var  aidr_pkg::aidr_byte_type rd_data,
    output var  logic                    rd_valid,
    // Channel indicators
    output var  logic [7:0]              ch_led
);
    import aidr_pkg::*;

    aidr_byte_type  ch_err_reg [8];
    aidr_byte_type  ch_err_next [8];
    aidr_byte_type  ch_sum_reg;
    logic           comm_err_reg;
    aidr_stamp_type stamp_reg;
    aidr_stamp_type us_now;
    logic           event_now;

    // ************************************************************
    // Microsecond ticker
    // ************************************************************
    aidr_ticker u_ticker (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .us_count (us_now)
    );

    // Build a channel error byte, reserved bits zero
    function automatic aidr_byte_type chan_byte(input logic par,
                                                input logic und,
                                                input logic ovr);
        aidr_byte_type b;
        b = 8'h00;
        b[`AIDR_CHANNEL_ERROR_SUMMARY_PARBIT] = par;
        b[`AIDR_CHANNEL_ERROR_SUMMARY_UNDBIT] = und;
        b[`AIDR_CHANNEL_ERROR_SUMMARY_OVRBIT] = ovr;
        return b;
    endfunction

    // ************************************************************
    // Per-channel error bytes, follow the live condition
    // ************************************************************
    generate
        for (genvar i = 0; i < 8; i++) begin : g_ch
            assign ch_err_next[i] = chan_byte(ch_param_err[i],
                                              ch_underflow[i],
                                              ch_overflow[i]);
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    ch_err_reg[i] <= 8'h00;
                    ch_sum_reg[i] <= 1'b0;
                    ch_led[i]     <= 1'b0;
                end else begin
                    ch_err_reg[i] <= ch_err_next[i];
                    ch_sum_reg[i] <= |ch_err_next[i];
                    ch_led[i]     <= |ch_err_next[i];
                end
            end
        end
    endgenerate

    // Internal communication error level
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            comm_err_reg <= 1'b0;
        end else begin
            comm_err_reg <= int_comm_err;
        end
    end

    // ************************************************************
    // Timestamp capture on any rising diagnostic condition
    // ************************************************************
    always_comb begin
        event_now = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if ((ch_err_next[i] & ~ch_err_reg[i]) != 8'h00) begin
                event_now = 1'b1;
            end
        end
        if (int_comm_err && !comm_err_reg) begin
            event_now = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stamp_reg <= 32'h0000_0000;
        end else if (event_now) begin
            stamp_reg <= us_now;
        end
    end

    // ************************************************************
    // Record read decode, unmapped bytes read zero
    // ************************************************************
    function automatic aidr_byte_type rec_byte(input aidr_addr_type a);
        aidr_byte_type b;
        b = 8'h00;
        if (a == `AIDR_OFF_DIAG_A) begin
            b[`AIDR_DIAGA_CHBIT] = |ch_sum_reg;
        end else if (a == `AIDR_OFF_MODINFO) begin
            b[3:0] = `AIDR_CLASS_ANALOG;
            b[`AIDR_MODINFO_CHBIT] = 1'b1;
        end else if (a == `AIDR_OFF_DIAG_D) begin
            b[`AIDR_DIAGD_COMBIT] = comm_err_reg;
        end else if (a == `AIDR_OFF_CHTYPE) begin
            b[6:0] = `AIDR_CHTYPE_AI;
        end else if (a == `AIDR_OFF_DIAG_BITS_PER_CHANNEL) begin
            b = `AIDR_DIAG_BITS_PER_CHANNEL_VAL;
        end else if (a == `AIDR_OFF_CHANNEL_COUNT) begin
            b = `AIDR_CHANNEL_COUNT_VAL;
        end else if (a == `AIDR_OFF_CHSUM) begin
            b = ch_sum_reg;
        end else if (a >= `AIDR_OFF_CHERR0 && a <= `AIDR_OFF_CHERR7) begin
            b = ch_err_reg[3'(a - `AIDR_OFF_CHERR0)];
        end else if (a >= `AIDR_OFF_TS0 && a <= `AIDR_OFF_TS3) begin
            b = stamp_reg[8 * 2'(a - `AIDR_OFF_TS0) +: 8];
        end
        return b;
    endfunction

    // Registered read answer; no interrupt exists
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= rec_byte(rd_addr);
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/aidr_record_chk.sv
// Purpose: Port checks of the diagnostic record
// Assumes: One clock, rst synchronous active high
// Notes:   Bound to aidr_record
`default_nettype none
module aidr_record_chk (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // Inputs
    input wire logic [7:0] ch_param_err,
    input wire logic [7:0] ch_underflow,
    input wire logic [7:0] ch_overflow,
    input wire logic       rd_en,
    input wire logic [4:0] rd_addr,
    // Outputs
    input wire logic [7:0] rd_data,
    input wire logic [7:0] ch_led
);
    // ****************
    // Properties
    // ****************
    logic [7:0] err_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Errors of the previous edge
    always_ff @(posedge clk_sys) begin
        err_reg <= rst ? 8'h00 : ch_param_err | ch_underflow | ch_overflow;
    end
    property p_mod; rd_en && rd_addr == 5'h01 |=> rd_data == 8'h15; endproperty
    a_mod: assert property (p_mod) else $error("mod");
    property p_typ; rd_en && rd_addr == 5'h04 |=> rd_data == 8'h71; endproperty
    a_typ: assert property (p_typ) else $error("typ");
    property p_nbt; rd_en && rd_addr == 5'h05 |=> rd_data == 8'h08; endproperty
    a_nbt: assert property (p_nbt) else $error("nbt");
    property p_nch; rd_en && rd_addr == 5'h06 |=> rd_data == 8'h08; endproperty
    a_nch: assert property (p_nch) else $error("nch");
    property p_rsv; rd_en && (rd_addr == 5'h02 || rd_addr > 5'h14)
        |=> rd_data == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("rsv");
    property p_led; ch_led == err_reg; endproperty
    a_led: assert property (p_led) else $error("led");
    property p_sum; rd_en && rd_addr == 5'h07 |=> rd_data == $past(ch_led);
    endproperty
    a_sum: assert property (p_sum) else $error("sum");
    property p_dga; rd_en && rd_addr == 5'h00
        |=> rd_data[3] == |$past(ch_led); endproperty
    a_dga: assert property (p_dga) else $error("dga");
    c_sum: cover property (rd_en && rd_addr == 5'h07 ##1 rd_data != 8'h00);
    c_led: cover property (ch_led == 8'h80);
    c_ts: cover property (rd_en && rd_addr == 5'h14);
endmodule
bind aidr_record aidr_record_chk chk_u (
    .clk_sys(clk_sys), .rst(rst), .ch_param_err(ch_param_err),
    .ch_underflow(ch_underflow), .ch_overflow(ch_overflow),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .ch_led(ch_led)
);
`default_nettype wire

// file: tb/aidr_reader.sv
// Purpose: Backplane reader of the diagnostic record
// Assumes: Requests launched on the falling edge
// Notes:   Address shows its inverse between reads
`default_nettype none
module aidr_reader (
    // Clock
    input  wire logic       clk_sys,
    // Read port
    output var  logic       rd_en,
    output var  logic [4:0] rd_addr,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************
    // Read cycle
    // ****************
    initial begin
        rd_en = 1'b0;
        rd_addr = 5'h00;
    end
    // Request over one edge, answer taken a cycle on
    task automatic read(input logic [4:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk_sys);
        rd_en = 1'b0;
        rd_addr = ~a;
        d = (rd_valid === 1'b1) ? rd_data : 8'hxx;
    endtask
endmodule
`default_nettype wire

// file: tb/tb_aidr_record.sv
// Purpose: Self-checking bench of the diagnostic record
// Assumes: 40 MHz clock, inputs moved on the falling edge
// Notes:   Ticker wrap is out of reach in run length
`default_nettype none
module tb_aidr_record;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************
    // Bench
    // ****************
    logic       clk_sys;
    logic       rst;
    logic       int_comm_err;
    logic       rd_en;
    logic       rd_valid;
    logic [4:0] rd_addr;
    logic [7:0] ch_param_err;
    logic [7:0] ch_underflow;
    logic [7:0] ch_overflow;
    logic [7:0] ch_led;
    logic [7:0] rd_data;
    logic [7:0] got;
    int         err_total = 0;
    int         checks = 0;
    int         cyc = 0;
    aidr_record dut_u (.clk_sys(clk_sys), .rst(rst),
        .ch_param_err(ch_param_err), .ch_underflow(ch_underflow),
        .ch_overflow(ch_overflow), .int_comm_err(int_comm_err),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .ch_led(ch_led));
    aidr_reader rdr_u (.clk_sys(clk_sys), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
    // Clock and cycles since reset
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= rst ? 0 : cyc + 1;
    task automatic chk(input string n, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        rdr_u.read(a, got);
        chk($sformatf("byte %h", a), e, got);
    endtask
    task automatic t_stamp();
        int lo;
        int hi;
        logic [31:0] ts;
        for (int i = 0; i < 4; i++) rd(5'h11 + i[4:0], 8'h00);
        repeat (400) @(negedge clk_sys);
        lo = (cyc - 2) / 40;
        hi = cyc / 40 + 1;
        ch_overflow = 8'h01;
        for (int i = 0; i < 4; i++) begin
            rdr_u.read(5'h11 + i[4:0], got);
            ts[8*i +: 8] = got;
        end
        checks++;
        if ((ts >= lo && ts <= hi) !== 1'b1) begin
            err_total++;
            $display("wrong value stamp exp %0d got %h", lo, ts);
        end
        ch_overflow = 8'h00;
    endtask
    task automatic t_const();
        rd(5'h01, 8'h15);
        rd(5'h04, 8'h71);
        rd(5'h05, 8'h08);
        rd(5'h06, 8'h08);
        rd(5'h02, 8'h00);
        rd(5'h10, 8'h00);
        int_comm_err = 1'b1;
        repeat (2) @(negedge clk_sys);
        rd(5'h03, 8'h10);
        int_comm_err = 1'b0;
        repeat (2) @(negedge clk_sys);
        rd(5'h03, 8'h00);
    endtask
    task automatic t_chan();
        logic [7:0] m;
        logic [7:0] e;
        for (int n = 0; n < 8; n++) begin
            m = 8'h01 << n;
            for (int k = 0; k < 4; k++) begin
                ch_param_err = (k == 0) ? m : 8'h00;
                ch_underflow = (k == 1) ? m : 8'h00;
                ch_overflow = (k == 2) ? m : 8'h00;
                repeat (2) @(negedge clk_sys);
                chk("led", k < 3 ? m : 8'h00, ch_led);
                e = (k == 0) ? 8'h01 : (k == 1) ? 8'h40 : 8'h80;
                e = (k < 3) ? e : 8'h00;
                rd(5'h08 + n[4:0], e);
                rd(5'h07, k < 3 ? m : 8'h00);
                rd(5'h00, k < 3 ? 8'h08 : 8'h00);
            end
        end
    endtask
    task automatic final_report();
        if (err_total == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        int_comm_err = 1'b0;
        ch_param_err = 8'h00;
        ch_underflow = 8'h00;
        ch_overflow = 8'h00;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        t_stamp();
        t_const();
        t_chan();
        final_report();
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        final_report();
    end
endmodule
`default_nettype wire
